//--- logic/conversion_ready_sequencer.v
// Purpose: ready flag sequencing around calibration and conversion
// Assumes: i_clk is the master clock; pins are asynchronous to it
// Notes:   o_ready_n high means no fresh word; low means a word waits
//
// Functional notes
// - ready flag goes high as soon as calibration begins.
// - near calibration end, sample the convert request level.
// - sampled request high: flag falls exactly at calibration end, no conversion.
// - sampled request low: convert right after calibration, flag stays high.
// - each conversion end drops the flag and strobes the load; the result word is loaded one clock later.
// - flag rises after every result bit has been shifted out.
// - select high and word unread: flag rises two clocks before next result.
// - slave mode, select low, nothing read: flag rises two clocks before result.
// - low convert request starts conversion unless busy; held low repeats.
// - calibrate high at reset release calibrates; else rising calibrate when idle.
// - result shifts msb first on rising shift clock; output floats when deselected.
`timescale 1ns/10ps
`default_nettype none
`include "ready_seq_consts.vh"

module conversion_ready_sequencer #(
  parameter WORD_BITS   = `WORD_BITS,
  parameter CAL_CYCLES  = `CAL_CYCLES,
  parameter CONVERT_REQUEST_N_CYCLES = `CONVERT_REQUEST_N_CYCLES,
  parameter SCLK_HALF   = `SCLK_HALF_CYCLES
) (
  input  wire                 i_clk,
  input  wire                 i_resetn,
  input  wire                 i_calibrate,
  input  wire                 i_convert_request_n,
  input  wire                 i_select_n,
  input  wire                 i_sclk,
  input  wire                 i_port_role_select,
  input  wire [WORD_BITS-1:0] i_result_word,
  output reg                  o_ready_n,
  output wire                 o_serial_result_out,
  output reg                  o_serial_result_out_oe,
  output reg                  o_sclk_out,
  output reg                  o_sclk_oe,
  output reg                  o_calibrating,
  output reg                  o_converting
);

  // one-hot states
  localparam [3:0] ST_BOOT = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_CAL  = 4'h4;
  localparam [3:0] ST_CONVERT_REQUEST_N = 4'h8;

  // end points worked out at full width, then cut to the counter width on purpose
  localparam integer CAL_LAST_W   = CAL_CYCLES - 1;
  localparam integer CAL_SAMPLE_W = CAL_CYCLES - 1 - `CAL_SAMPLE_LEAD;
  localparam integer CONVERT_REQUEST_N_LAST_W  = CONVERT_REQUEST_N_CYCLES - 1;
  localparam integer CONVERT_REQUEST_N_RAISE_W = CONVERT_REQUEST_N_CYCLES - 1 - `READY_LEAD_CYCLES;
  localparam integer BOOT_LAST_W  = `BOOT_WAIT_CYCLES - 1;
  localparam integer SCLK_LAST_W  = SCLK_HALF - 1;

  localparam [`CNT_BITS-1:0] CAL_LAST    = CAL_LAST_W[`CNT_BITS-1:0];
  localparam [`CNT_BITS-1:0] CAL_SAMPLE  = CAL_SAMPLE_W[`CNT_BITS-1:0];
  localparam [`CNT_BITS-1:0] CONVERT_REQUEST_N_LAST   = CONVERT_REQUEST_N_LAST_W[`CNT_BITS-1:0];
  localparam [`CNT_BITS-1:0] CONVERT_REQUEST_N_RAISE  = CONVERT_REQUEST_N_RAISE_W[`CNT_BITS-1:0];
  localparam [`CNT_BITS-1:0] BOOT_LAST   = BOOT_LAST_W[`CNT_BITS-1:0];
  localparam [`CNT_BITS-1:0] SCLK_LAST   = SCLK_LAST_W[`CNT_BITS-1:0];

  reg  [1:0]            rst_sync_reg;
  wire                  rst_n;
  reg  [4:0]            sync1_reg;
  reg  [4:0]            sync2_reg;
  reg                   cal_prev_reg;
  reg                   sclk_prev_reg;
  reg  [3:0]            state_reg;
  reg  [`CNT_BITS-1:0]  cnt_reg;
  reg  [`CNT_BITS-1:0]  div_reg;
  reg                   convert_request_n_sampled_reg;
  reg                   pending_reg;
  reg                   read_started_reg;
  reg                   load_reg;
  wire                  shift_done;
  wire                  cal_s;
  wire                  convert_request_n_n_s;
  wire                  cs_n_s;
  wire                  slave_mode;
  wire                  sclk_rise;
  wire                  own_rise;
  wire                  shift_pulse;
  wire                  convert_request_n_end;

  // ----------------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // first stage feeds only the second; edge detectors look at stage two
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg     <= `SY_RESET_VAL;
      sync2_reg     <= `SY_RESET_VAL;
      cal_prev_reg  <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg     <= {i_port_role_select, i_sclk, i_select_n,
                        i_convert_request_n, i_calibrate};
      sync2_reg     <= sync1_reg;
      cal_prev_reg  <= sync2_reg[`SY_CAL];
      sclk_prev_reg <= sync2_reg[`SY_SCLK];
    end
  end

  assign cal_s      = sync2_reg[`SY_CAL];
  assign convert_request_n_n_s   = sync2_reg[`SY_CONVERT_REQUEST_N_N];
  assign cs_n_s     = sync2_reg[`SY_CS_N];
  assign slave_mode = ~sync2_reg[`SY_ROLE];
  assign sclk_rise  = sync2_reg[`SY_SCLK] & ~sclk_prev_reg;

  // ----------------------------------------------------------------------
  // shift clock source: controller's clock in slave mode, own divider else
  // ----------------------------------------------------------------------
  // the divider only runs while a word waits and the port is selected
  assign own_rise    = ~slave_mode & ~o_sclk_out & (div_reg == SCLK_LAST);
  assign shift_pulse = pending_reg & ~cs_n_s & ~load_reg
                       & (slave_mode ? sclk_rise : own_rise);

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg    <= {`CNT_BITS{1'b0}};
      o_sclk_out <= 1'b0;
      o_sclk_oe  <= 1'b0;
    end else begin
      o_sclk_oe <= ~slave_mode & ~cs_n_s;
      if (slave_mode | cs_n_s | ~pending_reg) begin
        div_reg    <= {`CNT_BITS{1'b0}};
        o_sclk_out <= 1'b0;
      end else if (div_reg == SCLK_LAST) begin
        div_reg    <= {`CNT_BITS{1'b0}};
        o_sclk_out <= ~o_sclk_out;
      end else begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // result output register
  // ----------------------------------------------------------------------
  result_shifter #(
    .WIDTH   (WORD_BITS)
  ) u_shifter (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_load  (load_reg),
    .i_word  (i_result_word),
    .i_shift (shift_pulse),
    .i_clear (cs_n_s),
    .o_bit   (o_serial_result_out),
    .o_done  (shift_done)
  );

  // data pin floats while deselected
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_serial_result_out_oe <= 1'b0;
    end else begin
      o_serial_result_out_oe <= ~cs_n_s;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer: calibration, conversion and the ready flag
  // ----------------------------------------------------------------------
  assign convert_request_n_end = state_reg[3] & (cnt_reg == CONVERT_REQUEST_N_LAST);

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= ST_BOOT;
      cnt_reg          <= {`CNT_BITS{1'b0}};
      convert_request_n_sampled_reg <= 1'b1;
      pending_reg      <= 1'b0;
      read_started_reg <= 1'b0;
      load_reg         <= 1'b0;
      o_ready_n        <= 1'b1;
      o_calibrating    <= 1'b0;
      o_converting     <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      // readout bookkeeping; a load in the same cycle overrides below
      if (shift_pulse) begin
        read_started_reg <= 1'b1;
      end
      if (shift_done) begin
        pending_reg <= 1'b0;
        o_ready_n   <= 1'b1;
      end
      case (state_reg)
        ST_BOOT: begin
          // wait until the strap has crossed the synchroniser
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == BOOT_LAST) begin
            cnt_reg <= {`CNT_BITS{1'b0}};
            if (cal_s) begin
              state_reg     <= ST_CAL;
              o_calibrating <= 1'b1;
              o_ready_n     <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
              o_ready_n <= 1'b0;
            end
          end
        end
        ST_IDLE: begin
          cnt_reg <= {`CNT_BITS{1'b0}};
          if (cal_s & ~cal_prev_reg) begin
            state_reg     <= ST_CAL;
            o_calibrating <= 1'b1;
            o_ready_n     <= 1'b1;
          end else if (~convert_request_n_n_s) begin
            state_reg    <= ST_CONVERT_REQUEST_N;
            o_converting <= 1'b1;
          end
        end
        ST_CAL: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CAL_SAMPLE) begin
            convert_request_n_sampled_reg <= convert_request_n_n_s;
          end
          if (cnt_reg == CAL_LAST) begin
            cnt_reg       <= {`CNT_BITS{1'b0}};
            o_calibrating <= 1'b0;
            if (convert_request_n_sampled_reg) begin
              state_reg <= ST_IDLE;
              o_ready_n <= 1'b0;
            end else begin
              state_reg    <= ST_CONVERT_REQUEST_N;
              o_converting <= 1'b1;
            end
          end
        end
        ST_CONVERT_REQUEST_N: begin
          cnt_reg <= cnt_reg + 1'b1;
          // early raise so a waiting controller sees the flag fall again
          if ((cnt_reg == CONVERT_REQUEST_N_RAISE) & pending_reg
              & (cs_n_s | (slave_mode & ~read_started_reg))) begin
            o_ready_n <= 1'b1;
          end
          if (convert_request_n_end) begin
            cnt_reg          <= {`CNT_BITS{1'b0}};
            load_reg         <= 1'b1;
            pending_reg      <= 1'b1;
            read_started_reg <= 1'b0;
            o_ready_n        <= 1'b0;
            if (convert_request_n_n_s) begin
              state_reg    <= ST_IDLE;
              o_converting <= 1'b0;
            end else begin
              state_reg <= ST_CONVERT_REQUEST_N;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- logic/ready_seq_consts.vh
// Purpose: shared constants of the conversion ready sequencer
// Assumes: included by bare name from the design files
// Notes:   times are in ns; the conversion cycle count derives from the 25 ns master clock
`ifndef READY_SEQ_CONSTS_VH
`define READY_SEQ_CONSTS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define CONVERT_REQUEST_N_TIME_NS      5000
// conversion length, rounded down to whole master clock cycles
`define CONVERT_REQUEST_N_CYCLES       ((`CONVERT_REQUEST_N_TIME_NS) / (`CLK_PERIOD_NS))
`define CAL_CYCLES        1024
`define CAL_SAMPLE_LEAD   4
`define READY_LEAD_CYCLES 2
`define BOOT_WAIT_CYCLES  3
`define SCLK_HALF_CYCLES  2

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define WORD_BITS         16
`define CNT_BITS          16
`define BITCNT_BITS       5

// ----------------------------------------------------------------------
// synchroniser bit positions and reset values
// ----------------------------------------------------------------------
`define SY_CAL            0
`define SY_CONVERT_REQUEST_N_N         1
`define SY_CS_N           2
`define SY_SCLK           3
`define SY_ROLE           4
`define SY_RESET_VAL      5'h06

`endif

//--- logic/result_shifter.v
// Purpose: serial output register for the result word
// Assumes: one clock; load and shift are single-cycle strobes
// Notes:   msb first; done pulses once after the last bit has left
`timescale 1ns/10ps
`default_nettype none
`include "ready_seq_consts.vh"

module result_shifter #(
  parameter WIDTH = `WORD_BITS
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_word,
  input  wire             i_shift,
  input  wire             i_clear,
  output reg              o_bit,
  output reg              o_done
);

  reg [WIDTH-1:0]            shift_reg;
  reg [`BITCNT_BITS-1:0]     count_reg;

  // ----------------------------------------------------------------------
  // shift register and bit counter
  // ----------------------------------------------------------------------
  // load wins over shift so a fresh word is never skewed by a stray edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= {WIDTH{1'b0}};
      count_reg <= {`BITCNT_BITS{1'b0}};
      o_bit     <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        shift_reg <= i_word;
        o_bit     <= i_word[WIDTH-1];
        count_reg <= {`BITCNT_BITS{1'b0}};
      end else if (i_clear) begin
        count_reg <= {`BITCNT_BITS{1'b0}};
      end else if (i_shift) begin
        shift_reg <= {shift_reg[WIDTH-2:0], 1'b0};
        o_bit     <= shift_reg[WIDTH-2];
        count_reg <= count_reg + 1'b1;
        if (count_reg == WIDTH[`BITCNT_BITS-1:0] - 1'b1) begin
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/ready_seq_props.sv
// Purpose: concurrent checks on the ready sequencer ports
// Assumes: one master clock; reset active low
// Notes:   counts follow the parameters handed on by the bind
`timescale 1ns/10ps
`default_nettype none
module ready_seq_props #(
  parameter CAL_CYCLES  = 32,
  parameter CONVERT_REQUEST_N_CYCLES = 24
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_calibrate,
  input wire logic i_convert_request_n,
  input wire logic i_select_n,
  input wire logic i_port_role_select,
  input wire logic o_ready_n,
  input wire logic o_serial_result_out_oe,
  input wire logic o_sclk_oe,
  input wire logic o_calibrating,
  input wire logic o_converting
);
  // ----------------------------------------------------------------
  // timing relations
  // ----------------------------------------------------------------
  // the flag falls at the last count edge, so it is sampled low one edge later
  localparam int CONVERT_REQUEST_N_END = CONVERT_REQUEST_N_CYCLES;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_cal_flag; o_calibrating |-> o_ready_n; endproperty
  a_cal_flag: assert property (p_cal_flag) else $error("flag low in calibration");
  property p_cal_end; $fell(o_calibrating) |-> o_converting == o_ready_n; endproperty
  a_cal_end: assert property (p_cal_end) else $error("wrong flag at calibration end");
  property p_cal_convert_request_n; $fell(o_calibrating) && o_converting |-> o_ready_n [*8]; endproperty
  a_cal_convert_request_n: assert property (p_cal_convert_request_n) else $error("flag fell early");
  property p_convert_request_n_len; $rose(o_converting) |-> ##CONVERT_REQUEST_N_END !o_ready_n; endproperty
  a_convert_request_n_len: assert property (p_convert_request_n_len) else $error("no flag at conversion end");
  property p_convert_request_n_fall; $fell(o_converting) |-> !o_ready_n; endproperty
  a_convert_request_n_fall: assert property (p_convert_request_n_fall) else $error("flag high after conversion");
  property p_busy; !(o_converting && o_calibrating); endproperty
  a_busy: assert property (p_busy) else $error("conversion inside calibration");
  property p_cal_cause; $rose(o_calibrating) |-> $past(i_calibrate, 3); endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("calibration without request");
  property p_role; !i_port_role_select [*4] |-> !o_sclk_oe; endproperty
  a_role: assert property (p_role) else $error("clock driven in slave role");
  property p_float; i_select_n [*4] |-> !o_serial_result_out_oe; endproperty
  a_float: assert property (p_float) else $error("data driven while deselected");
endmodule
bind conversion_ready_sequencer ready_seq_props #(
  .CAL_CYCLES(CAL_CYCLES), .CONVERT_REQUEST_N_CYCLES(CONVERT_REQUEST_N_CYCLES)
) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_calibrate(i_calibrate),
  .i_convert_request_n(i_convert_request_n), .i_select_n(i_select_n),
  .i_port_role_select(i_port_role_select), .o_ready_n(o_ready_n),
  .o_serial_result_out_oe(o_serial_result_out_oe), .o_sclk_oe(o_sclk_oe),
  .o_calibrating(o_calibrating), .o_converting(o_converting)
);
`default_nettype wire

//--- tb/controller_model.sv
// Purpose: controller that selects the port and clocks the result out
// Assumes: slave role; 8 master cycles per shift clock period
// Notes:   shift clock stands low outside frames
`timescale 1ns/10ps
`default_nettype none
module controller_model (
  input  wire logic i_clk,
  input  wire logic i_data,
  output var  logic o_select_n,
  output var  logic o_sclk
);
  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
  end
  // select, then read n bits; data taken at the falling edge to avoid races
  task automatic read_bits(input int n, output logic [15:0] w);
    w = 16'h0000;
    @(posedge i_clk) o_select_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk) w = {w[14:0], i_data};
      @(posedge i_clk) o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask
  task automatic deselect();
    @(posedge i_clk) o_select_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb/conversion_ready_sequencer_tb.sv
// Purpose: sequences of conversions, calibrations and readouts
// Assumes: short calibration and conversion counts
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/10ps
`default_nettype none
module conversion_ready_sequencer_tb;
  logic clk = 0, resetn = 0, cal = 1, convert_request_n_n = 1, role = 0, last_bit = 0;
  logic [15:0] word = 16'hA5C3, got;
  wire sel_n, sclk, rdy_n, serial_result_out, sdo_oe, sclk_o, sclk_oe, calib, convg;
  wire data_line = sdo_oe ? serial_result_out : ~last_bit;
  int bad_count = 0, comparisons = 0, cycles = 0, t0;
  logic sclk_o_d = 0, sdo_d = 0;
  logic [15:0] mword = 16'h0000;
  int mrises = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (sdo_oe) last_bit <= serial_result_out;
  // master readout: the bit standing before each own clock rise is the one sent
  always @(posedge clk) begin
    sclk_o_d <= sclk_o;
    sdo_d <= serial_result_out;
    if (sclk_o && !sclk_o_d) begin
      mword <= {mword[14:0], sdo_d};
      mrises <= mrises + 1;
    end
  end
  conversion_ready_sequencer #(.CAL_CYCLES(32), .CONVERT_REQUEST_N_CYCLES(24)) dut (
    .i_clk(clk), .i_resetn(resetn), .i_calibrate(cal), .i_convert_request_n(convert_request_n_n),
    .i_select_n(sel_n), .i_sclk(sclk), .i_port_role_select(role), .i_result_word(word),
    .o_ready_n(rdy_n), .o_serial_result_out(serial_result_out), .o_serial_result_out_oe(sdo_oe),
    .o_sclk_out(sclk_o), .o_sclk_oe(sclk_oe), .o_calibrating(calib), .o_converting(convg));
  controller_model partner (.i_clk(clk), .i_data(data_line), .o_select_n(sel_n),
    .o_sclk(sclk));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait: k selects flag, converting or calibrating
  task automatic wait_sig(input int k, input logic lvl);
    int n;
    n = 0;
    while ((k == 0 ? rdy_n : k == 1 ? convg : calib) !== lvl && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic convert();
    @(posedge clk) convert_request_n_n <= 1'b0;
    repeat (4) @(posedge clk);
    convert_request_n_n <= 1'b1;
  endtask
  // early raise must lead the next result by two master cycles
  task automatic lead();
    convert();
    wait_sig(0, 1);
    t0 = cycles;
    wait_sig(0, 0);
    check("raise lead", 16'(cycles - t0), 16'h0002);
  endtask
  // hang guard: the whole sequence fits well inside this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    check("reset flag", 16'(rdy_n), 16'h0001);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(negedge clk);
    check("strap calibration", 16'(calib), 16'h0001);
    check("flag in calibration", 16'(rdy_n), 16'h0001);
    @(posedge clk) cal <= 1'b0;
    wait_sig(2, 0);
    check("flag after calibration", 16'(rdy_n), 16'h0000);
    check("no conversion", 16'(convg), 16'h0000);
    convert();
    wait_sig(1, 1);
    wait_sig(1, 0);
    check("flag at result", 16'(rdy_n), 16'h0000);
    partner.read_bits(16, got);
    repeat (6) @(negedge clk);
    check("word", got, 16'hA5C3);
    check("flag after readout", 16'(rdy_n), 16'h0001);
    partner.deselect();
    word <= 16'h3C5A;
    convert();
    wait_sig(0, 0);
    partner.read_bits(8, got);
    repeat (6) @(negedge clk);
    check("half word", got, 16'h003C);
    check("flag after half", 16'(rdy_n), 16'h0000);
    partner.deselect();
    word <= 16'h5AA5;
    lead();
    partner.read_bits(16, got);
    check("word after raise", got, 16'h5AA5);
    partner.deselect();
    word <= 16'hC33C;
    convert();
    wait_sig(0, 0);
    partner.read_bits(0, got);
    lead();
    partner.read_bits(16, got);
    check("slave word", got, 16'hC33C);
    partner.deselect();
    @(posedge clk) convert_request_n_n <= 1'b0;
    wait_sig(1, 1);
    wait_sig(0, 0);
    @(negedge clk);
    check("back to back", 16'(convg), 16'h0001);
    @(posedge clk) convert_request_n_n <= 1'b1;
    wait_sig(1, 0);
    @(posedge clk) cal <= 1'b1;
    convert_request_n_n <= 1'b0;
    word <= 16'h96E1;
    wait_sig(2, 1);
    @(posedge clk) cal <= 1'b0;
    wait_sig(2, 0);
    check("convert after calibration", 16'(convg), 16'h0001);
    check("flag held", 16'(rdy_n), 16'h0001);
    @(posedge clk) convert_request_n_n <= 1'b1;
    wait_sig(1, 0);
    // master role: the block clocks the waiting word out by itself
    @(posedge clk) role <= 1'b1;
    partner.read_bits(0, got);
    check("master clock drive", 16'(sclk_oe), 16'h0001);
    wait_sig(0, 1);
    repeat (2) @(negedge clk);
    check("master word", mword, 16'h96E1);
    check("master edges", 16'(mrises), 16'h0010);
    check("master clock idle", 16'(sclk_o), 16'h0000);
    check("flag after master readout", 16'(rdy_n), 16'h0001);
    partner.deselect();
    role <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
